// ==== verilog/fbm_cfg.svh ====
// Timing counts, command codes and field widths for the flash bus host
`ifndef FBM_CFG_SVH
`define FBM_CFG_SVH
`define FBM_CLK_NS 20
`define FBM_ADDR_W 22
`define FBM_DATA_W 16
`define FBM_STATUS_RESET 8'h80
`define FBM_CMD_READ_ARRAY 8'hFF
`define FBM_CMD_READ_STATUS 8'h70
`define FBM_CMD_PROGRAM 8'h40
`define FBM_CMD_ERASE 8'h20
`define FBM_CMD_ERASE_CONFIRM 8'hD0
`define FBM_RESET_PULSE_NS 100
`define FBM_ABORT_SHUTDOWN_NS 22000
`define FBM_RESET_TO_READ_NS 150
`define FBM_RESET_TO_WRITE_NS 150
`define FBM_STROBE_NS 70
`define FBM_RESET_PULSE_CYC ((`FBM_RESET_PULSE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_ABORT_CYC ((`FBM_ABORT_SHUTDOWN_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_RESET_TO_READ_CYC ((`FBM_RESET_TO_READ_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_RESET_TO_WRITE_CYC ((`FBM_RESET_TO_WRITE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_STROBE_CYC ((`FBM_STROBE_NS + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`endif

// ==== verilog/fbm_pkg.sv ====
// Types for the flash bus host controller
package fbm_pkg;
    typedef enum logic [2:0] {
        FBM_IDLE,
        FBM_RESET,
        FBM_WAKE,
        FBM_SETUP,
        FBM_STROBE,
        FBM_HOLD
    } fbm_state_e;
endpackage

// ==== verilog/fbm_host.sv ====
// Host-side controller driving a parallel flash through its bus pins
// Summary of operation
// - Read: reset high, write strobe high, chip select and output enable low.
// - Host waits read and write wake-up delays after reset release.
// - After abort, wake-up delays count from end of shutdown.
// - Write only with select and strobe low, output enable and reset high.
// - Host writes a read-mode command to change read mode.
// - Lockable blocks change only with write-protect held high.
// - Flash reset comes from the same reset as the processor.
// - Host writes FFH before array data after program or erase.
`timescale 1ns/100ps
`default_nettype none
`include "fbm_cfg.svh"
module fbm_host (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`FBM_ADDR_W-1:0] req_addr,
    input wire logic [`FBM_DATA_W-1:0] req_wdata,
    input wire logic req_byte_mode,
    input wire logic req_wp,
    input wire logic req_reset,
    input wire logic req_abort,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`FBM_DATA_W-1:0] rsp_rdata,
    output logic busy_op,
    output logic [`FBM_ADDR_W-1:0] flash_addr,
    output logic [`FBM_DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [`FBM_DATA_W-1:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic reset_powerdown_n,
    output logic flash_wp
);
    localparam int unsigned RST_CYC = `FBM_RESET_PULSE_CYC;
    localparam int unsigned ABT_CYC = `FBM_ABORT_CYC;
    localparam int unsigned RD_CYC = `FBM_RESET_TO_READ_CYC;
    localparam int unsigned WR_CYC = `FBM_RESET_TO_WRITE_CYC;
    localparam int unsigned WAKE_CYC = (RD_CYC > WR_CYC) ? RD_CYC : WR_CYC;
    localparam int unsigned STB_CYC = `FBM_STROBE_CYC;
    localparam logic [7:0] CMD_PROG = `FBM_CMD_PROGRAM;
    localparam logic [7:0] CMD_ERASE = `FBM_CMD_ERASE;

    fbm_pkg::fbm_state_e state_q, state_d;
    logic [10:0] cnt_q, cnt_d;
    logic write_q, write_d;
    logic byte_q, byte_d;
    logic op_q, op_d;
    logic [`FBM_ADDR_W-1:0] addr_q, addr_d;
    logic [`FBM_DATA_W-1:0] wdata_q, wdata_d;
    logic [`FBM_DATA_W-1:0] rdata_q, rdata_d;
    logic rsp_q, rsp_d;
    logic ce_q, ce_d, oe_q, oe_d, we_q, we_d, rp_q, rp_d, dqoe_q, dqoe_d;
    logic wp_q, wp_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        write_d = write_q;
        byte_d = byte_q;
        op_d = op_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rsp_d = 1'b0;
        // Idle bus: deselected, strobes high, data released
        ce_d = 1'b1;
        oe_d = 1'b1;
        we_d = 1'b1;
        dqoe_d = 1'b0;
        rp_d = 1'b1;
        wp_d = wp_q;
        case (state_q)
            fbm_pkg::FBM_IDLE: begin
                if (req_reset || req_abort) begin
                    // Abort while busy needs the longer shutdown window
                    cnt_d = (op_q && req_abort) ? 11'(ABT_CYC) : 11'(RST_CYC);
                    op_d = 1'b0;
                    rp_d = 1'b0;
                    state_d = fbm_pkg::FBM_RESET;
                end else if (req_valid) begin
                    write_d = req_write;
                    byte_d = req_byte_mode;
                    addr_d = req_addr;
                    wdata_d = req_byte_mode ? {8'h00, req_wdata[7:0]} : req_wdata;
                    wp_d = req_wp;
                    // Program and erase set-up leave the flash busy until reset or host clears
                    if (req_write && (req_wdata[7:0] == CMD_PROG || req_wdata[7:0] == CMD_ERASE))
                        op_d = 1'b1;
                    else if (req_write)
                        op_d = 1'b0;
                    cnt_d = 11'(STB_CYC);
                    state_d = fbm_pkg::FBM_SETUP;
                end
            end
            fbm_pkg::FBM_RESET: begin
                rp_d = 1'b0;
                if (cnt_q > 11'd1) begin
                    cnt_d = cnt_q - 11'd1;
                end else if (!req_reset && !req_abort) begin
                    rp_d = 1'b1;
                    cnt_d = 11'(WAKE_CYC);
                    state_d = fbm_pkg::FBM_WAKE;
                end
            end
            fbm_pkg::FBM_WAKE: begin
                // Flash returns in read-array mode; no command needed
                if (cnt_q > 11'd1)
                    cnt_d = cnt_q - 11'd1;
                else
                    state_d = fbm_pkg::FBM_IDLE;
            end
            fbm_pkg::FBM_SETUP: begin
                ce_d = 1'b0;
                if (write_q) begin
                    dqoe_d = 1'b1;
                    we_d = 1'b0;
                end else begin
                    oe_d = 1'b0;
                end
                state_d = fbm_pkg::FBM_STROBE;
            end
            fbm_pkg::FBM_STROBE: begin
                ce_d = 1'b0;
                dqoe_d = write_q;
                if (cnt_q > 11'd1) begin
                    cnt_d = cnt_q - 11'd1;
                    we_d = !write_q;
                    oe_d = write_q;
                end else begin
                    // WE rises before CE so the flash latches on the strobe edge
                    we_d = 1'b1;
                    oe_d = 1'b1;
                    if (!write_q) begin
                        rdata_d = byte_q ? {8'h00, flash_dq_in[7:0]} : flash_dq_in;
                        rsp_d = 1'b1;
                    end
                    state_d = fbm_pkg::FBM_HOLD;
                end
            end
            fbm_pkg::FBM_HOLD: begin
                // Data held one cycle past the strobe for hold time
                dqoe_d = 1'b0;
                state_d = fbm_pkg::FBM_IDLE;
            end
            default: state_d = fbm_pkg::FBM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // Flash held in reset along with the host
            state_q <= fbm_pkg::FBM_RESET;
            cnt_q <= 11'(RST_CYC);
            write_q <= 1'b0;
            byte_q <= 1'b0;
            op_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            rsp_q <= 1'b0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            rp_q <= 1'b0;
            dqoe_q <= 1'b0;
            wp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            write_q <= write_d;
            byte_q <= byte_d;
            op_q <= op_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rsp_q <= rsp_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            rp_q <= rp_d;
            dqoe_q <= dqoe_d;
            wp_q <= wp_d;
        end
    end

    logic ready_q;
    always_ff @(posedge core_clk) begin
        if (!rst_b)
            ready_q <= 1'b0;
        else
            ready_q <= (state_d == fbm_pkg::FBM_IDLE);
    end

    assign req_ready = ready_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign busy_op = op_q;
    assign flash_addr = addr_q;
    assign flash_dq_out = wdata_q;
    assign flash_dq_oe = dqoe_q;
    assign flash_ce_n = ce_q;
    assign flash_oe_n = oe_q;
    assign flash_we_n = we_q;
    assign reset_powerdown_n = rp_q;
    assign flash_wp = wp_q;
endmodule
`default_nettype wire

// ==== sim/fbm_host_checker.sv ====
// Bus-pin timing checks for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module fbm_host_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic rsp_valid,
    input wire logic flash_dq_oe,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic reset_powerdown_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence write_pulse;
        !flash_we_n ##1 flash_we_n;
    endsequence
    a_read_ctrl_levels: assert property (!flash_oe_n |-> flash_we_n && reset_powerdown_n && !flash_ce_n) else $error("read strobes wrong");
    a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid) else $error("rsp_valid too long");
    a_rsp_after_read: assert property (rsp_valid |-> !$past(flash_oe_n)) else $error("rsp without read");
    a_no_bus_fight: assert property (flash_dq_oe |-> flash_oe_n) else $error("dq driven in read");
    a_write_ctrl_levels: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && reset_powerdown_n && flash_dq_oe) else $error("write strobes wrong");
    a_write_latch_stable: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out)) else $error("write data moved");
    a_we_rises_first: assert property (write_pulse |-> !flash_ce_n) else $error("ce rose before we");
    a_reset_deselect: assert property (!reset_powerdown_n |-> flash_ce_n && !flash_dq_oe) else $error("selected in reset");
    a_reset_pulse_len: assert property ($fell(reset_powerdown_n) |-> !reset_powerdown_n [*5]) else $error("reset pulse short");
    a_wake_wait: assert property ($rose(reset_powerdown_n) |-> flash_ce_n [*8]) else $error("access before wake");
endmodule
bind fbm_host fbm_host_checker fbm_host_checker_i (.core_clk, .rst_b, .rsp_valid, .flash_dq_oe,
    .flash_addr, .flash_dq_out, .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n);
`default_nettype wire

// ==== sim/fbm_flash_model.sv ====
// Behavioural flash device on the host's bus pins
`timescale 1ns/100ps
`default_nettype none
module fbm_flash_model (
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic reset_powerdown_n,
    output logic [15:0] flash_dq_in
);
    logic [15:0] mem [int];
    logic [15:0] rd;
    logic [15:0] last_q = 16'h0000;
    int mode = 0;
    always @(negedge reset_powerdown_n) mode = 0;
    // Latch on whichever of we or ce rises first
    always @(posedge flash_we_n or posedge flash_ce_n) begin
        if (reset_powerdown_n && flash_oe_n && flash_we_n != flash_ce_n) begin
            if (mode == 2) begin
                mem[flash_addr] = flash_dq_out;
                mode = 1;
            end else if (flash_dq_out[7:0] == 8'hFF) mode = 0;
            else if (flash_dq_out[7:0] == 8'h40) mode = 2;
            else if (flash_dq_out[7:0] == 8'h70 || flash_dq_out[7:0] == 8'h20) mode = 1;
        end
    end
    always @* rd = mode != 0 ? 16'h0080 : mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
    always @(posedge flash_oe_n) last_q = rd;
    // Floating bus shows the inverse of the last value, not a stale copy
    always @* flash_dq_in = reset_powerdown_n && !flash_ce_n && !flash_oe_n ? rd : ~last_q;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench: host against a behavioural flash and a reference memory
`timescale 1ns/100ps
`default_nettype none
`include "fbm_cfg.svh"
module tb_top;
    logic core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_byte_mode = 1'b0, req_wp = 1'b1, req_reset = 1'b0, req_abort = 1'b0;
    logic [21:0] req_addr = 22'h000000;
    logic [21:0] flash_addr, a;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] rsp_rdata, flash_dq_out, flash_dq_in, got, d;
    logic req_ready, rsp_valid, busy_op, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
    logic reset_powerdown_n, flash_wp;
    int n_errors = 0, samples_checked = 0, cycles = 0, seed = 75903;
    int rp_low = 0, lo0 = 0;
    logic [15:0] ref_mem [int];
    always #10 core_clk = ~core_clk;
    fbm_host fbm_host_i (.core_clk, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_byte_mode, .req_wp, .req_reset, .req_abort, .req_ready, .rsp_valid, .rsp_rdata,
        .busy_op, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n,
        .flash_oe_n, .flash_we_n, .reset_powerdown_n, .flash_wp);
    fbm_flash_model fbm_flash_model_i (.flash_addr, .flash_dq_out, .flash_ce_n, .flash_oe_n,
        .flash_we_n, .reset_powerdown_n, .flash_dq_in);
    task automatic complete_run;
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Samples before the edge's own updates land, so no race with the design
    task automatic op(input logic w, input logic [21:0] ad, input logic [15:0] wd);
        logic wpv;
        // Program and erase need write-protect high; reads take a random level
        wpv = w ? 1'b1 : 1'($random(seed));
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_wdata <= wd;
        req_wp <= wpv;
        @(posedge core_clk);
        req_valid <= 1'b0;
        if (!w) begin
            do @(posedge core_clk); while (rsp_valid !== 1'b1);
            got = rsp_rdata;
        end else begin
            // Let the cycle finish so state read afterwards has settled
            do @(posedge core_clk); while (req_ready !== 1'b1);
        end
        check("flash_wp", {15'h0000, wpv}, {15'h0000, flash_wp});
    endtask
    function automatic logic [15:0] expect_at(input logic [21:0] ad);
        return ref_mem.exists(ad) ? ref_mem[ad] : 16'hFFFF;
    endfunction
    task automatic flash_reset(input logic ab);
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_reset <= !ab;
        req_abort <= ab;
        repeat (3) @(posedge core_clk);
        req_reset <= 1'b0;
        req_abort <= 1'b0;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (reset_powerdown_n === 1'b0)
            rp_low++;
        if (cycles == 8000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        a = 22'($random(seed));
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", 16'hFFFF, got);
        op(1'b1, 22'h000000, 16'h0070);
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", 16'h0080, got);
        for (int i = 0; i < 5; i++) begin
            a = 22'($random(seed));
            d = 16'($random(seed));
            op(1'b1, a, 16'h0040);
            check("busy_op", 1'b1, busy_op);
            op(1'b1, a, d);
            ref_mem[a] = d;
            op(1'b0, a ^ 22'h000001, 16'h0000);
            check("rsp_rdata", 16'h0080, got);
            op(1'b1, a, 16'h00FF);
            check("busy_op", 1'b0, busy_op);
            op(1'b0, a, 16'h0000);
            check("rsp_rdata", expect_at(a), got);
        end
        op(1'b1, a, 16'h0020);
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", 16'h0080, got);
        lo0 = rp_low;
        flash_reset(1'b0);
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", expect_at(a), got);
        check("rp_low_cycles", 16'(`FBM_RESET_PULSE_CYC), 16'(rp_low - lo0));
        req_byte_mode <= 1'b1;
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", expect_at(a) & 16'h00FF, got);
        req_byte_mode <= 1'b0;
        op(1'b1, a ^ 22'h000002, 16'h0040);
        lo0 = rp_low;
        flash_reset(1'b1);
        op(1'b0, a, 16'h0000);
        check("rsp_rdata", expect_at(a), got);
        check("rp_low_cycles", 16'(`FBM_ABORT_CYC), 16'(rp_low - lo0));
        check("busy_op", 1'b0, busy_op);
        complete_run();
    end
endmodule
`default_nettype wire
